// [tmr_defines.svh]
// offsets, field positions, reset values and timing counts of the timer block
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define ADDR_COUNT        2'h0
`define ADDR_OPTION       2'h1
`define ADDR_INTCTL       2'h2
`define ADDR_WDT          2'h3
`define OPT_CS_BIT        5
`define OPT_SE_BIT        4
`define OPT_PSA_BIT       3
`define INT_FLAG_BIT      2
`define INT_EN_BIT        5
`define OPTION_RST        8'hFF
`define COUNT_RST         8'h00
`define INTCTL_RST        8'h00
`define QPHASE_CYCLES     2'h3
`define WR_INHIBIT_CYC    2'h2
`endif

// [tmr_pkg.sv]
// types shared by the timer block
package tmr_pkg;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;
	typedef struct packed {
		logic       cs;
		logic       se;
		logic       prescaler_assign;
		logic [2:0] ratio;
	} opt_t;
endpackage : tmr_pkg

// [tmr_prescaler.sv]
// shared 8-bit prescaler counter with tap select
`include "tmr_defines.svh"
module tmr_prescaler (
	// clock and control
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       clr,
	input  wire logic       tick,
	// selection
	input  wire logic [2:0] ratio,
	input  wire logic       bypass,
	// output
	output logic            out_level
);
	import tmr_pkg::*;
	typedef struct packed {
		logic [7:0] cnt;
	} pre_state_t;
	pre_state_t st_r;
	pre_state_t st_nxt;

	// count ticks; cleared on demand
	always_comb begin
		st_nxt = st_r;
		if (clr) begin
			st_nxt.cnt = 8'h00;
		end else if (tick) begin
			st_nxt.cnt = st_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '{cnt: 8'h00};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// symmetric output: bit k gives 1:2^(k+1)
	assign out_level = bypass ? 1'b0 : st_r.cnt[ratio];
endmodule : tmr_prescaler

// [tmr_core.sv]
// 8-bit timer/counter with a prescaler shared with the watchdog
//
// Our own choices: the plain strobed port and the register addresses.
`include "tmr_defines.svh"
module tmr_core (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	// register port
	input  wire tmr_pkg::reg_req_t req,
	output logic [7:0]            rdata,
	// pins and system
	input  wire logic             external_count_input,
	input  wire logic             sleep,
	input  wire logic             watchdog_clear_instr,
	input  wire logic             watchdog_tick,
	// outputs
	output logic                  irq,
	output logic                  watchdog_post
);
	import tmr_pkg::*;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_t;

	typedef struct packed {
		logic [7:0] count_register;
		opt_t       opt;
		logic       overflow_flag;
		logic       overflow_irq_enable;
		logic [2:0] pin_sync;
		logic       pin_stable;
		logic       pre_samp;
		logic       pre_prev;
		phase_t     phase;
		logic [1:0] inhibit;
		logic [7:0] rdata;
		logic       wdt_pre_prev;
	} core_state_t;

	core_state_t st_r;
	core_state_t st_nxt;

	logic       pre_out;
	logic       pre_tick;
	logic       pre_clr;
	logic       pin_edge;
	logic       cyc_end;
	logic       wr_count;
	logic       inc;
	logic       psa_wdt;
	logic       src_level;

	assign psa_wdt  = st_r.opt.prescaler_assign;
	assign cyc_end  = (st_r.phase == PH_Q4);
	assign wr_count = req.wr && (req.addr == `ADDR_COUNT);

	// counted edge after edge select; pin_stable is the agreed synchronised level
	assign src_level = st_r.pin_stable ^ st_r.opt.se;
	// one-cycle pulse: stages 2 and 3 agree on the selected level while the accepted level differs
	assign pin_edge  = (st_r.pin_sync[2] == st_r.pin_sync[1]) &&
		(st_r.pin_sync[1] ^ st_r.opt.se) && !src_level;

	// prescaler input: pin edges or instruction cycles, or watchdog ticks
	always_comb begin
		if (psa_wdt) begin
			pre_tick = watchdog_tick;
		end else if (st_r.opt.cs) begin
			pre_tick = pin_edge;
		end else begin
			pre_tick = cyc_end && !sleep;
		end
	end

	// clear by count write or watchdog clear, per assignment
	assign pre_clr = (!psa_wdt && wr_count) ||
		(psa_wdt && watchdog_clear_instr);

	// single shared prescaler, not visible on the register port
	tmr_prescaler u_pre (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.clr       (pre_clr),
		.tick      (pre_tick && !sleep),
		.ratio     (st_r.opt.ratio),
		.bypass    (1'b0),
		.out_level (pre_out)
	);

	// watchdog postscaler output when assigned there
	assign watchdog_post = psa_wdt && pre_out && !st_r.wdt_pre_prev;

	// next state
	always_comb begin
		st_nxt = st_r;
		inc    = 1'b0;
		st_nxt.phase = phase_t'(st_r.phase + 2'h1);
		if (sleep) begin
			st_nxt.phase = st_r.phase;
		end
		// three-flop pin synchroniser, level accepted when stages 2 and 3 agree
		st_nxt.pin_sync = {st_r.pin_sync[1:0], external_count_input};
		if (st_r.pin_sync[2] == st_r.pin_sync[1]) begin
			st_nxt.pin_stable = st_r.pin_sync[2];
		end
		st_nxt.wdt_pre_prev = pre_out;
		// sample the prescaler output on second and fourth quarter phases
		if (st_r.phase == PH_Q2 || st_r.phase == PH_Q4) begin
			st_nxt.pre_samp = pre_out;
		end
		// increment source
		if (!sleep) begin
			if (psa_wdt) begin
				// 1:1 rate: each counted event increments directly
				inc = st_r.opt.cs ? pin_edge : cyc_end;
			end else if (cyc_end) begin
				// falling edge of sampled prescaler output, lagging the pin
				inc = st_r.pre_prev && !st_r.pre_samp;
				st_nxt.pre_prev = st_r.pre_samp;
			end
		end
		if (cyc_end && st_r.inhibit != 2'h0) begin
			st_nxt.inhibit = st_r.inhibit - 2'h1;
		end
		if (inc && st_r.inhibit == 2'h0) begin
			st_nxt.count_register = st_r.count_register + 8'h01;
			if (st_r.count_register == 8'hFF) begin
				st_nxt.overflow_flag = 1'b1;
			end
		end
		// register writes; a write does not clear a flag set in the same cycle
		if (req.wr) begin
			unique case (req.addr)
				`ADDR_COUNT: begin
					st_nxt.count_register = req.wdata;
					st_nxt.inhibit        = `WR_INHIBIT_CYC;
				end
				`ADDR_OPTION: begin
					st_nxt.opt.cs    = req.wdata[`OPT_CS_BIT];
					st_nxt.opt.se    = req.wdata[`OPT_SE_BIT];
					st_nxt.opt.prescaler_assign   = req.wdata[`OPT_PSA_BIT];
					st_nxt.opt.ratio = req.wdata[2:0];
				end
				`ADDR_INTCTL: begin
					st_nxt.overflow_irq_enable = req.wdata[`INT_EN_BIT];
					st_nxt.overflow_flag = req.wdata[`INT_FLAG_BIT] ||
						(st_nxt.overflow_flag && !st_r.overflow_flag);
				end
				`ADDR_WDT: begin
				end
			endcase
		end
		// read data for the next cycle; prescaler count has no address
		st_nxt.rdata = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				`ADDR_COUNT:  st_nxt.rdata = st_r.count_register;
				`ADDR_OPTION: st_nxt.rdata = {2'b11, st_r.opt.cs, st_r.opt.se,
					st_r.opt.prescaler_assign, st_r.opt.ratio};
				`ADDR_INTCTL: st_nxt.rdata = {2'b00, st_r.overflow_irq_enable, 2'b00,
					st_r.overflow_flag, 2'b00};
				`ADDR_WDT:    st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '{count_register: `COUNT_RST,
				opt: opt_t'(6'(`OPTION_RST)),
				overflow_flag: 1'b0,
				overflow_irq_enable: 1'b0,
				pin_sync: 3'b000,
				pin_stable: 1'b0,
				pre_samp: 1'b0,
				pre_prev: 1'b0,
				phase: PH_Q1,
				inhibit: 2'h0,
				rdata: 8'h00,
				wdt_pre_prev: 1'b0};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// masked interrupt output
	assign irq   = st_r.overflow_flag && st_r.overflow_irq_enable;
	assign rdata = st_r.rdata;

	// assertions
	sequence s_wrap;
		clk_en && !req.wr && inc && st_r.inhibit == 2'h0 && st_r.count_register == 8'hFF;
	endsequence
	AST_OVF_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_wrap |=> st_r.overflow_flag && st_r.count_register == 8'h00)
		else $error("overflow did not set flag");
	AST_WR_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && wr_count |=> st_r.count_register == $past(req.wdata) && st_r.inhibit == 2'h2)
		else $error("count write not taken");
	AST_INHIBIT: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r.inhibit != 2'h0 && clk_en && !req.wr |=> st_r.count_register == $past(st_r.count_register))
		else $error("count moved while inhibited");
	AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (sys_rst)
		!st_r.overflow_irq_enable |-> !irq)
		else $error("masked interrupt asserted");
	AST_SLEEP: assert property (@(posedge core_clk) disable iff (sys_rst)
		sleep && !req.wr |=> st_r.count_register == $past(st_r.count_register))
		else $error("count moved in sleep");
	AST_PRE_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && wr_count && !psa_wdt |=> u_pre.st_r.cnt == 8'h00)
		else $error("prescaler not cleared by count write");
	AST_WDT_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && watchdog_clear_instr && psa_wdt |=> u_pre.st_r.cnt == 8'h00)
		else $error("prescaler not cleared by watchdog clear");
	AST_RD_OPT: assert property (@(posedge core_clk) disable iff (sys_rst)
		req.rd && req.addr == `ADDR_OPTION && clk_en |=> rdata[2:0] == $past(st_r.opt.ratio))
		else $error("option readback wrong");
	AST_TIMER_RATE: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && psa_wdt && !st_r.opt.cs && !sleep && !req.wr && cyc_end &&
		st_r.inhibit == 2'h0 |=> st_r.count_register == $past(st_r.count_register) + 8'h01)
		else $error("timer mode missed a cycle");

	// option and interrupt-control writes as named steps
	sequence s_opt_write;
		clk_en && req.wr && req.addr == `ADDR_OPTION;
	endsequence
	sequence s_ctl_write;
		clk_en && req.wr && req.addr == `ADDR_INTCTL;
	endsequence

	// phase counter advances once per clock while awake
	AST_PHASE_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !sleep |=> st_r.phase == phase_t'($past(st_r.phase) + 2'h1))
		else $error("phase did not advance");

	// phase counter holds during sleep
	AST_PHASE_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && sleep |=> st_r.phase == $past(st_r.phase))
		else $error("phase moved in sleep");

	// an accepted pin edge is a single-cycle pulse
	AST_EDGE_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && pin_edge |=> !pin_edge)
		else $error("pin edge longer than one cycle");

	// unprescaled counter mode takes every accepted edge
	AST_CTR_DIRECT: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && psa_wdt && st_r.opt.cs && !sleep && pin_edge && !req.wr &&
		st_r.inhibit == 2'h0 |=> st_r.count_register == $past(st_r.count_register) + 8'h01)
		else $error("counter mode missed an edge");

	// with the prescaler here, the count moves only at the end of an instruction cycle
	AST_PRE_ONLY_Q4: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !psa_wdt && !cyc_end && !req.wr |=>
		st_r.count_register == $past(st_r.count_register))
		else $error("prescaled count moved off the instruction boundary");

	// prescaled increments come only at Q4, from the sample taken at Q2
	AST_INC_LAG: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !psa_wdt && inc |-> cyc_end)
		else $error("prescaled increment outside Q4");

	// pin edges feed the prescaler when it is assigned to the timer
	AST_PRE_PIN_TICK: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !psa_wdt && st_r.opt.cs && pin_edge && !sleep && !pre_clr |=>
		u_pre.st_r.cnt == $past(u_pre.st_r.cnt) + 8'h01)
		else $error("pin edge did not reach the prescaler");

	// under the watchdog, only watchdog ticks or clears move the prescaler
	AST_WDT_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && psa_wdt && !watchdog_tick && !watchdog_clear_instr |=>
		u_pre.st_r.cnt == $past(u_pre.st_r.cnt))
		else $error("prescaler moved without a watchdog tick");

	// prescaler freezes in sleep unless cleared
	AST_PRE_SLEEP: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && sleep && !pre_clr |=> u_pre.st_r.cnt == $past(u_pre.st_r.cnt))
		else $error("prescaler moved in sleep");

	// sample register changes only on the second and fourth quarter phases
	AST_SAMPLE_PHASE: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && st_r.phase != PH_Q2 && st_r.phase != PH_Q4 |=>
		st_r.pre_samp == $past(st_r.pre_samp))
		else $error("prescaler sampled off Q2/Q4");

	// pin synchroniser shifts by one stage per clock
	AST_SYNC_SHIFT: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en |=> st_r.pin_sync[1] == $past(st_r.pin_sync[0]))
		else $error("synchroniser did not shift");

	// inhibit counts down once per instruction cycle
	AST_INHIBIT_DEC: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && cyc_end && st_r.inhibit != 2'h0 && !wr_count |=>
		st_r.inhibit == $past(st_r.inhibit) - 2'h1)
		else $error("inhibit did not count down");

	// count read returns the count of the request cycle
	AST_RD_COUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && req.rd && req.addr == `ADDR_COUNT |=> rdata == $past(st_r.count_register))
		else $error("count readback wrong");

	// read data is zero outside the cycle after a read
	AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !req.rd |=> rdata == 8'h00)
		else $error("read data not idle");

	// hardware never clears the flag
	AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && st_r.overflow_flag && !(req.wr && req.addr == `ADDR_INTCTL) |=>
		st_r.overflow_flag)
		else $error("overflow flag dropped by hardware");

	// enable bit follows a control write
	AST_EN_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_ctl_write |=> st_r.overflow_irq_enable == $past(req.wdata[`INT_EN_BIT]))
		else $error("enable bit not written");

	// assignment bit follows an option write
	AST_OPT_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_opt_write |=> st_r.opt.prescaler_assign == $past(req.wdata[`OPT_PSA_BIT]))
		else $error("assignment bit not written");

	// watchdog output is a single-cycle pulse
	AST_POST_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && watchdog_post |=> !watchdog_post)
		else $error("watchdog output longer than one cycle");
endmodule : tmr_core

// [ext_clk_src.sv]
// external clock source model driving the count pin
module ext_clk_src (
	// count pin
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin idles low between bursts
	initial pin = 1'b0;
	// full pulses; widths kept above the minimum high and low times
	task automatic pulse(input int n, input int hi_ns, input int lo_ns);
		repeat (n) begin
			pin = 1'b1;
			#(hi_ns);
			pin = 1'b0;
			#(lo_ns);
		end
	endtask : pulse
	// single level change for edge checks
	task automatic level(input logic v);
		pin = v;
	endtask : level
endmodule : ext_clk_src

// [eight_bit_timer_with_shared_prescaler_tb_top.sv]
// testbench of the timer block with its external clock source
`include "tmr_defines.svh"
module eight_bit_timer_with_shared_prescaler_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	logic       core_clk, sys_rst, clk_en, sleep, wd_clr, wd_tick, irq, wd_post, pin;
	reg_req_t   req;
	logic [7:0] rdata, d, a;
	int         err_count, n_tests, posts;
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	tmr_core i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
		.rdata(rdata), .external_count_input(pin), .sleep(sleep),
		.watchdog_clear_instr(wd_clr), .watchdog_tick(wd_tick), .irq(irq),
		.watchdog_post(wd_post));
	ext_clk_src i_src (.pin(pin));
	// count watchdog output pulses
	always @(posedge core_clk) if (wd_post === 1'b1) posts <= posts + 1;
	// one comparison, reported at once on mismatch
	task automatic chk(input bit ok, input logic [7:0] got, input string what);
		n_tests++;
		if (!ok) begin
			err_count++;
			$display("[ERR] %0t %s: got %h", $time, what, got);
		end
	endtask : chk
	// register bus write and read
	task automatic wr(input logic [1:0] ad, input logic [7:0] v);
		@(posedge core_clk);
		req <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] ad);
		@(posedge core_clk);
		req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic t_reset();
		rd(`ADDR_OPTION);
		chk(d === 8'hFF, d, "option reset");
		rd(`ADDR_COUNT);
		chk(d === 8'h00, d, "count reset");
		rd(`ADDR_INTCTL);
		chk(d === 8'h00, d, "intctl reset");
		wr(`ADDR_WDT, 8'h5A);
		rd(`ADDR_WDT);
		chk(d === 8'h00, d, "unmapped read");
		$display("reset test done");
	endtask : t_reset
	// timer mode, assigned to watchdog so rate 1:1, write inhibit
	task automatic t_timer();
		wr(`ADDR_OPTION, 8'h08);
		wr(`ADDR_COUNT, 8'h10);
		repeat (4) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d === 8'h10, d, "inhibit after write");
		repeat (36) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d >= 8'h17 && d <= 8'h19, d, "instruction rate");
		$display("timer test done");
	endtask : t_timer
	task automatic t_ovf();
		wr(`ADDR_INTCTL, 8'h00);
		wr(`ADDR_COUNT, 8'hFE);
		repeat (30) @(posedge core_clk);
		rd(`ADDR_INTCTL);
		chk(d === 8'h04, d, "overflow flag");
		chk(irq === 1'b0, irq, "masked irq");
		wr(`ADDR_INTCTL, 8'h24);
		@(posedge core_clk);
		#1 chk(irq === 1'b1, irq, "enabled irq");
		wr(`ADDR_INTCTL, 8'h00);
		rd(`ADDR_INTCTL);
		chk(d === 8'h00 && irq === 1'b0, d, "flag cleared");
		$display("overflow test done");
	endtask : t_ovf
	task automatic t_sleep();
		@(posedge core_clk);
		sleep <= 1'b1;
		rd(`ADDR_COUNT);
		a = d;
		repeat (40) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d === a, d, "stopped in sleep");
		@(posedge core_clk);
		sleep <= 1'b0;
		$display("sleep test done");
	endtask : t_sleep
	// counter mode, both edge choices, unprescaled
	task automatic t_edges();
		wr(`ADDR_OPTION, 8'h28);
		wr(`ADDR_COUNT, 8'h00);
		repeat (12) @(posedge core_clk);
		i_src.pulse(5, 40, 40);
		repeat (20) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d === 8'h05, d, "external count");
		i_src.level(1'b1);
		repeat (20) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d === 8'h06, d, "rising counted");
		i_src.level(1'b0);
		wr(`ADDR_OPTION, 8'h38);
		wr(`ADDR_COUNT, 8'h00);
		repeat (12) @(posedge core_clk);
		i_src.level(1'b1);
		repeat (20) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d === 8'h00, d, "rising ignored");
		i_src.level(1'b0);
		repeat (20) @(posedge core_clk);
		rd(`ADDR_COUNT);
		chk(d === 8'h01, d, "falling counted");
		$display("edge test done");
	endtask : t_edges
	// prescaled counter mode, ratio codes 0 to 2
	task automatic t_ratio();
		for (int r = 0; r < 3; r++) begin
			wr(`ADDR_OPTION, 8'h20 | 8'(r));
			wr(`ADDR_COUNT, 8'h00);
			repeat (12) @(posedge core_clk);
			i_src.pulse(8, 40, 40);
			repeat (30) @(posedge core_clk);
			rd(`ADDR_COUNT);
			chk(d === 8'(8 >> (r + 1)), d, "prescale ratio");
		end
		$display("ratio test done");
	endtask : t_ratio
	// prescaler as watchdog postscaler at 1:2
	task automatic t_wdog();
		wr(`ADDR_OPTION, 8'h08);
		@(posedge core_clk);
		wd_clr <= 1'b1;
		@(posedge core_clk);
		wd_clr <= 1'b0;
		posts = 0;
		repeat (8) begin
			@(posedge core_clk);
			wd_tick <= 1'b1;
			@(posedge core_clk);
			wd_tick <= 1'b0;
			repeat (6) @(posedge core_clk);
		end
		chk(posts == 4, 8'(posts), "watchdog postscale");
		$display("watchdog test done");
	endtask : t_wdog
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// reset, then the scenarios in turn
	initial begin
		req = '0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		sleep = 1'b0;
		wd_clr = 1'b0;
		wd_tick = 1'b0;
		err_count = 0;
		n_tests = 0;
		posts = 0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_timer();
		t_ovf();
		t_sleep();
		t_edges();
		t_ratio();
		t_wdog();
		wrap_up();
	end
	// hang guard, far beyond the roughly one thousand cycles the scenarios need
	initial begin
		#50us;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : eight_bit_timer_with_shared_prescaler_tb_top
